// file: verilog/tsm_frame_sync.sv
// Contract
// - Multiframe is 72 frames of 193 bits.
// - Sync on 24-bit pattern over F-bits.
// - Frame one holds pattern's first one.
// - Out-of-frame status low while aligned.
// - Boundary indication at each multiframe start.
// - Odd-frame F-bits alternate one and zero.
// - Even frames 2-22 pattern, frame 72 zero.
// - Even frames 24-70 carry overhead bits.
// - Every sixth frame robs bit 8, ABCD.
// - Keep checking F-bits once aligned.
// - Two Ft errors per six frames: severe, in the 12-frame format only.
// - Each F-bit error flags and reports.
// - Too many errors means loss of sync.
// - Auto reframe only when enable is one.
// - Manual reframe on rising trigger edge.
// - No error reporting while out of sync.
// - Changed alignment position flags and reports.
// - Sticky indications, write one clears, masked irq.
`timescale 1ns/1ps
module tsm_frame_sync
   import tsm_pkg::*;
#(
   parameter logic [5:0] LOSS_WIN = 6'h10, // F-bits per loss window.
   parameter logic [5:0] LOSS_TH0 = 6'h02, // Errors allowed, select 0.
   parameter logic [5:0] LOSS_TH1 = 6'h03,
   parameter logic [5:0] LOSS_TH2 = 6'h04,
   parameter logic [5:0] LOSS_TH3 = 6'h06
)
(
   input  wire logic              clk_sys_i,                 // 100 MHz.
   input  wire logic              reset_i,                   // Sync, high.
   input  wire logic              rx_line_clk_i,             // Line clock pin.
   input  wire logic              rx_line_bit_i,             // Line data pin.
   input  wire logic              slc_format_i,              // 1: 72 frames.
   input  wire logic [1:0]        loss_threshold_select_i,   // Loss ratio.
   input  wire logic              auto_reframe_enable_i,     // Auto hunt.
   input  wire logic              manual_reframe_trigger_i,  // Rise: hunt.
   input  wire logic [IND_W-1:0]  ind_clear_i,               // Write-one.
   input  wire logic [IND_W-1:0]  ind_enable_i,              // Irq mask.
   output logic                   out_of_frame_status_o,     // 1: no sync.
   output logic                   multiframe_boundary_ind_o, // Sticky.
   output logic                   severe_framing_error_ind_o,// Sticky.
   output logic                   framing_bit_error_ind_o,   // Sticky.
   output logic                   alignment_change_ind_o,    // Sticky.
   output logic                   oof_change_ind_o,          // Sticky.
   output logic                   irq_o,                     // Enabled ind.
   output logic                   pm_fbit_err_o,             // Pulse.
   output logic                   pm_align_change_o,         // Pulse.
   output logic                   oh_valid_o,                // Pulse.
   output logic                   oh_bit_o,                  // Overhead bit.
   output logic [6:0]             oh_frame_o,                // Frame number.
   output logic                   word_valid_o,              // Word ready.
   input  wire logic              word_ready_i,              // Taker ready.
   output logic [WORD_W-1:0]      word_data_o,               // Channel word.
   output logic                   word_drop_o                // Lost word.
);

   ////////////////////////////////////////////////////////////////////////////
   // Line pins pass three flops; a level counts once stages two and three
   // agree, so a line bit is taken on a settled rising line clock.
   logic [2:0] lclk_sync_ff;
   logic [2:0] lbit_sync_ff;
   logic       lclk_lvl_ff;

   always_ff @(posedge clk_sys_i)
   begin
      lclk_sync_ff <= {lclk_sync_ff[1:0], rx_line_clk_i};
      lbit_sync_ff <= {lbit_sync_ff[1:0], rx_line_bit_i};
      if (reset_i)
         lclk_lvl_ff <= 1'b0;
      else if (lclk_sync_ff[1] == lclk_sync_ff[2])
         lclk_lvl_ff <= lclk_sync_ff[2];
   end

   wire bit_stb = lclk_sync_ff[1] & lclk_sync_ff[2] & ~lclk_lvl_ff;
   wire rx_bit  = lbit_sync_ff[2];

   ////////////////////////////////////////////////////////////////////////////
   // Frame state registers.
   tsm_state_t  state_ff;
   logic [7:0]  pos_ff;      // Free running bit position.
   logic [7:0]  cand_ff;     // F-bit position under test or in use.
   logic [7:0]  prev_pos_ff; // Last aligned F-bit position.
   logic        have_prev_ff;
   logic [23:0] fsh_ff;      // F-bits seen while hunting.
   logic [6:0]  srch_ff;     // F-bits tried at this candidate.
   logic [6:0]  frm_ff;      // Current frame, zero based.
   logic [3:0]  sub_ff;      // Position inside the superframe.
   logic [1:0]  sig_ff;      // Letter of the next robbed frame.
   logic [2:0]  sev_win_ff;
   logic [1:0]  sev_cnt_ff;
   logic [5:0]  lw_ff;
   logic [5:0]  ea_ff;
   logic [5:0]  eb_ff;
   logic        man_q_ff;
   logic        oof_q_ff;

   // Picks the loss threshold for the select field.
   function automatic logic [5:0] loss_thr(input logic [1:0] sel);
      case (sel)
         2'h0:    loss_thr = LOSS_TH0;
         2'h1:    loss_thr = LOSS_TH1;
         2'h2:    loss_thr = LOSS_TH2;
         default: loss_thr = LOSS_TH3;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Hunt: collect F-bits at the candidate, match, or slip one bit.
   wire        in_sync   = (state_ff == ST_SYNC);
   wire        hunting   = (state_ff == ST_SEARCH);
   wire        fpos      = bit_stb & (pos_ff == cand_ff);
   wire [23:0] nxt_fsh   = {fsh_ff[22:0], rx_bit};
   wire        fill_ok   = srch_ff >= (slc_format_i ? SLC_FILL : SF_FILL);
   wire        pat_hit   = slc_format_i ? (nxt_fsh == SLC_PAT)
                                        : (nxt_fsh[11:0] == SF_PAT);
   wire        match     = hunting & fpos & fill_ok & pat_hit;
   wire        slip      = hunting & fpos & ~pat_hit &
                           (srch_ff == (slc_format_i ? SLC_SRCH_LIM
                                                     : SF_SRCH_LIM));
   wire        man_rise  = manual_reframe_trigger_i & ~man_q_ff;
   wire [7:0]  nxt_pos   = (pos_ff == FRAME_LAST) ? 8'h00 : pos_ff + ONE_BIT;
   wire [7:0]  nxt_cand  = (cand_ff == FRAME_LAST) ? 8'h00
                                                   : cand_ff + ONE_BIT;
   wire        cofa_ev   = match & have_prev_ff & (cand_ff != prev_pos_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Frame counting and expected F-bits once aligned.
   wire [6:0]  last_frm  = slc_format_i ? SLC_LAST_FRM : SF_LAST_FRM;
   wire [6:0]  nxt_frm   = (frm_ff == last_frm) ? 7'h00 : frm_ff + 7'h01;
   wire [3:0]  nxt_sub   = (sub_ff == SUB_LAST) ? 4'h0 : sub_ff + 4'h1;
   wire        is_ft     = ~nxt_frm[0];
   wire        f72       = slc_format_i & (nxt_frm == SLC_LAST_FRM);
   wire        exp_bit   = f72 ? 1'b0 : SF_PAT[SUB_LAST - nxt_sub];
   wire        chk       = ~slc_format_i | is_ft | f72 |
                           (nxt_frm <= FS_CHK_LAST);
   wire        sync_f    = in_sync & fpos;
   wire        ferr      = sync_f & chk & (rx_bit != exp_bit);
   wire        ft_err    = ferr & is_ft;
   wire        robbed    = (sub_ff == ROB_SUB_A) | (sub_ff == ROB_SUB_B);
   wire        mfb_ev    = sync_f & (nxt_frm == 7'h00);
   wire        oh_ev     = sync_f & slc_format_i & nxt_frm[0] &
                           (nxt_frm >= OH_FIRST) & (nxt_frm <= OH_LAST);

   // Severe window and loss window counts.
   wire        sev_ev    = ~slc_format_i & ft_err &
                           (sev_cnt_ff == SEV_ONE);
   wire        cnt_a     = slc_format_i ? ft_err : ferr;
   wire        cnt_b     = slc_format_i & ferr & ~is_ft;
   wire [5:0]  nxt_ea    = ea_ff + {5'h00, cnt_a};
   wire [5:0]  nxt_eb    = eb_ff + {5'h00, cnt_b};
   wire [5:0]  thr       = loss_thr(loss_threshold_select_i);
   wire        loss      = sync_f & ((nxt_ea > thr) | (nxt_eb > thr));

   ////////////////////////////////////////////////////////////////////////////
   // State machine: hunt, aligned, or lost and waiting for a manual start.
   tsm_state_t nxt_state;
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SEARCH: if (match) nxt_state = ST_SYNC;
         ST_SYNC:
            if (man_rise)
               nxt_state = ST_SEARCH;
            else if (loss)
               nxt_state = auto_reframe_enable_i ? ST_SEARCH
                                                 : ST_HOLD;
         ST_HOLD:   if (man_rise) nxt_state = ST_SEARCH;
         default:   nxt_state = ST_SEARCH;
      endcase
   end

   // State, edge memory and position counter; reset starts a hunt.
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         state_ff <= ST_SEARCH;
         pos_ff   <= 8'h00;
         man_q_ff <= 1'b0;
         oof_q_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         man_q_ff <= manual_reframe_trigger_i;
         oof_q_ff <= out_of_frame_status_o;
         if (bit_stb)
            pos_ff <= nxt_pos;
      end
   end

   // Candidate position, hunt shift register and retry count.
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || (nxt_state == ST_SEARCH && !hunting) ||
          (hunting && man_rise) || slip)
      begin
         srch_ff <= 7'h00;
         fsh_ff  <= 24'h000000;
         if (slip)
            cand_ff <= nxt_cand;
         else if (reset_i)
            cand_ff <= 8'h00;
      end
      else if (hunting && fpos)
      begin
         srch_ff <= srch_ff + 7'h01;
         fsh_ff  <= nxt_fsh;
      end
   end

   // Previous alignment memory for change detection.
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         have_prev_ff <= 1'b0;
      else if (match)
         have_prev_ff <= 1'b1;
      if (match)
         prev_pos_ff <= cand_ff;
   end

   // Frame, superframe and robbed-letter counters; a match names frame 22
   // (or 12 in the superframe format) so frame 1 holds the first one.
   always_ff @(posedge clk_sys_i)
   begin
      if (match)
      begin
         frm_ff <= slc_format_i ? SLC_MATCH_FRM : SF_MATCH_FRM;
         sub_ff <= slc_format_i ? SLC_MATCH_SUB : SF_MATCH_SUB;
         sig_ff <= slc_format_i ? SLC_MATCH_SIG : SF_MATCH_SIG;
      end
      else if (sync_f)
      begin
         frm_ff <= nxt_frm;
         sub_ff <= nxt_sub;
         sig_ff <= (nxt_frm == 7'h00) ? 2'h0 : sig_ff + {1'b0, robbed};
      end
   end

   // Error windows restart at every alignment.
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || match)
      begin
         sev_win_ff <= 3'h0;
         sev_cnt_ff <= 2'h0;
         lw_ff      <= 6'h00;
         ea_ff      <= 6'h00;
         eb_ff      <= 6'h00;
      end
      else if (sync_f)
      begin
         sev_win_ff <= (sev_win_ff == SEV_WIN_LAST) ? 3'h0 : sev_win_ff + 3'h1;
         sev_cnt_ff <= (sev_win_ff == SEV_WIN_LAST) ? 2'h0 :
                       (ft_err && sev_cnt_ff != 2'h3) ? sev_cnt_ff + 2'h1
                                                      : sev_cnt_ff;
         lw_ff      <= (lw_ff == LOSS_WIN - 6'h01) ? 6'h00 : lw_ff + 6'h01;
         ea_ff      <= (lw_ff == LOSS_WIN - 6'h01) ? 6'h00 : nxt_ea;
         eb_ff      <= (lw_ff == LOSS_WIN - 6'h01) ? 6'h00 : nxt_eb;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky indications: a set in the clearing cycle wins.
   logic [IND_W-1:0] ind_ff;
   logic             pm_fbit_err_ff;
   logic             pm_cofa_ff;
   wire              oof_now = (state_ff != ST_SYNC);
   wire [IND_W-1:0]  ind_set = {oof_now != oof_q_ff, cofa_ev,
                                ferr, sev_ev, mfb_ev};
   wire [IND_W-1:0]  ind_src = {ind_set[IND_OOF], cofa_ev, ind_set[IND_FBE],
                                ind_set[IND_SEV], ind_set[IND_MFB]};

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         ind_ff         <= '0;
         pm_fbit_err_ff <= 1'b0;
         pm_cofa_ff     <= 1'b0;
      end
      else
      begin
         ind_ff         <= (ind_ff & ~ind_clear_i) | ind_src;
         pm_fbit_err_ff <= ferr;
         pm_cofa_ff     <= cofa_ev;
      end
   end

   assign out_of_frame_status_o      = oof_now;
   assign multiframe_boundary_ind_o  = ind_ff[IND_MFB];
   assign severe_framing_error_ind_o = ind_ff[IND_SEV];
   assign framing_bit_error_ind_o    = ind_ff[IND_FBE];
   assign alignment_change_ind_o     = ind_ff[IND_COFA];
   assign oof_change_ind_o           = ind_ff[IND_OOF];
   assign irq_o                      = |(ind_ff & ind_enable_i);
   assign pm_fbit_err_o              = pm_fbit_err_ff;
   assign pm_align_change_o          = pm_cofa_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Overhead F-bits and channel words; bit 8 of a robbed frame is tagged.
   logic             oh_valid_ff;
   logic             oh_bit_ff;
   logic [6:0]       oh_frame_ff;
   logic [6:0]       wsh_ff;
   logic             push_ff;
   logic [WORD_W-1:0] push_word_ff;
   logic             drop_ff;
   logic             buf_ready;
   wire [7:0]        rel  = (pos_ff >= cand_ff) ? pos_ff - cand_ff
                                                : pos_ff + FRAME_BITS - cand_ff;
   wire [7:0]        rel1 = rel - ONE_BIT;
   wire              dstb = bit_stb & in_sync & (pos_ff != cand_ff);
   wire              wend = dstb & (rel1[2:0] == BIT_LAST);

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         oh_valid_ff <= 1'b0;
         push_ff     <= 1'b0;
         drop_ff     <= 1'b0;
      end
      else
      begin
         oh_valid_ff <= oh_ev;
         push_ff     <= wend;
         drop_ff     <= push_ff & ~buf_ready;
      end
      if (oh_ev)
      begin
         oh_bit_ff   <= rx_bit;
         oh_frame_ff <= nxt_frm + 7'h01;
      end
      if (dstb)
         wsh_ff <= {wsh_ff[5:0], rx_bit};
      if (wend)
         push_word_ff <= {frm_ff, rel1[7:3], robbed, sig_ff,
                          wsh_ff, rx_bit};
   end

   assign oh_valid_o  = oh_valid_ff;
   assign oh_bit_o    = oh_bit_ff;
   assign oh_frame_o  = oh_frame_ff;
   assign word_drop_o = drop_ff;

   tsm_skid_buf #(.W(WORD_W)) u_buf
   (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .in_valid_i  (push_ff),
      .in_ready_o  (buf_ready),
      .in_data_i   (push_word_ff),
      .out_valid_o (word_valid_o),
      .out_ready_i (word_ready_i),
      .out_data_o  (word_data_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the frame logic.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   sequence man_edge_s;
      !manual_reframe_trigger_i ##1 manual_reframe_trigger_i;
   endsequence

   reset_oof_a: assert property ($fell(reset_i) |-> out_of_frame_status_o)
      else $error("Not out of frame after reset.");
   match_sync_a: assert property (match |=> !out_of_frame_status_o)
      else $error("Match did not clear out of frame.");
   frame_one_a: assert property (match && slc_format_i
                                 |=> frm_ff == SLC_MATCH_FRM)
      else $error("Match frame number wrong.");
   boundary_a: assert property (mfb_ev |=> multiframe_boundary_ind_o)
      else $error("Boundary indication missing.");
   fbit_err_a: assert property (ferr |=> pm_fbit_err_o && framing_bit_error_ind_o)
      else $error("F-bit error not reported.");
   suspend_a: assert property (!in_sync |=> !pm_fbit_err_o)
      else $error("Error reported while out of sync.");
   manual_a: assert property (man_edge_s |=> state_ff == ST_SEARCH)
      else $error("Manual reframe ignored.");
   hold_wait_a: assert property (loss && !auto_reframe_enable_i && !man_rise
                                 |=> state_ff == ST_HOLD [*2])
      else $error("Reframe without auto enable.");
   set_wins_a: assert property (ferr && ind_clear_i[IND_FBE]
                                |=> framing_bit_error_ind_o)
      else $error("Set lost to clear.");
   align_chg_a: assert property (cofa_ev |=> alignment_change_ind_o ##0
                                 pm_align_change_o ##1 !pm_align_change_o)
      else $error("Alignment change not reported.");

endmodule

// file: verilog/tsm_pkg.sv
package tsm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Frame geometry: one F-bit plus 24 channels of 8 bits per frame.
   localparam logic [7:0]  FRAME_LAST    = 8'hC0;  // Last bit index, 192.
   localparam logic [7:0]  FRAME_BITS    = 8'hC1;  // Bits per frame, 193.
   localparam logic [7:0]  ONE_BIT       = 8'h01;  // Offset of channel bits.
   localparam logic [2:0]  BIT_LAST      = 3'h7;   // Bit 8 of a channel.
   localparam logic [6:0]  SLC_LAST_FRM  = 7'h47;  // Frame 72, zero based.
   localparam logic [6:0]  SF_LAST_FRM   = 7'h0B;  // Frame 12, zero based.
   localparam logic [3:0]  SUB_LAST      = 4'hB;   // Superframe position 12.

   ////////////////////////////////////////////////////////////////////////////
   // Alignment patterns, oldest F-bit in the most significant place.
   localparam logic [23:0] SLC_PAT       = 24'h237237;
   localparam logic [11:0] SF_PAT        = 12'h8DC;
   localparam logic [6:0]  SLC_FILL      = 7'h17;  // F-bits needed first.
   localparam logic [6:0]  SF_FILL       = 7'h0B;
   localparam logic [6:0]  SLC_SRCH_LIM  = 7'h5F;  // Tries before a slip.
   localparam logic [6:0]  SF_SRCH_LIM   = 7'h17;
   localparam logic [6:0]  SLC_MATCH_FRM = 7'h15;  // Frame 22 on a match.
   localparam logic [3:0]  SLC_MATCH_SUB = 4'h9;
   localparam logic [1:0]  SLC_MATCH_SIG = 2'h3;   // Next robbed is D.
   localparam logic [6:0]  SF_MATCH_FRM  = 7'h0B;  // Frame 12 on a match.
   localparam logic [3:0]  SF_MATCH_SUB  = 4'hB;
   localparam logic [1:0]  SF_MATCH_SIG  = 2'h0;   // Next robbed is A.

   ////////////////////////////////////////////////////////////////////////////
   // Positions inside the 72-frame multiframe, the superframe and the severe window, zero based.
   localparam logic [6:0]  FS_CHK_LAST   = 7'h15;  // Frame 22.
   localparam logic [6:0]  OH_FIRST      = 7'h17;  // Frame 24.
   localparam logic [6:0]  OH_LAST       = 7'h45;  // Frame 70.
   localparam logic [3:0]  ROB_SUB_A     = 4'h5;   // Frames 6 and 12.
   localparam logic [3:0]  ROB_SUB_B     = 4'hB;
   localparam logic [2:0]  SEV_WIN_LAST  = 3'h5;   // Six-frame window.
   localparam logic [1:0]  SEV_ONE       = 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Indication vector layout and the channel word width.
   localparam int          IND_W         = 5;
   localparam int          IND_MFB       = 0;
   localparam int          IND_SEV       = 1;
   localparam int          IND_FBE       = 2;
   localparam int          IND_COFA      = 3;
   localparam int          IND_OOF       = 4;
   localparam int          WORD_W        = 23;

   typedef enum logic [2:0] {
      ST_SEARCH = 3'h1,
      ST_SYNC   = 3'h2,
      ST_HOLD   = 3'h4
   } tsm_state_t;

endpackage

// file: verilog/tsm_skid_buf.sv
`timescale 1ns/1ps
module tsm_skid_buf
#(
   parameter int W = 8
)
(
   input  wire logic         clk_sys_i,  // System clock.
   input  wire logic         reset_i,    // Synchronous reset.
   input  wire logic         in_valid_i, // Word offered.
   output logic              in_ready_o, // Space for a word.
   input  wire logic [W-1:0] in_data_i,  // Word in.
   output logic              out_valid_o,// Word available.
   input  wire logic         out_ready_i,// Receiver takes it.
   output logic [W-1:0]      out_data_o  // Oldest word, from a flop.
);

   logic [W-1:0] head_ff;
   logic [W-1:0] tail_ff;
   logic [1:0]   cnt_ff;
   wire          push = in_valid_i & in_ready_o;
   wire          pop  = out_valid_o & out_ready_i;

   // Two entries: the head always feeds the output directly.
   assign in_ready_o  = (cnt_ff != 2'h2);
   assign out_valid_o = (cnt_ff != 2'h0);
   assign out_data_o  = head_ff;

   // Occupancy follows pushes and pops.
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         cnt_ff <= 2'h0;
      else
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
   end

   // Head loads from the tail or the input, tail holds the second word.
   always_ff @(posedge clk_sys_i)
   begin
      if (pop && cnt_ff == 2'h2)
         head_ff <= tail_ff;
      else if (push && (cnt_ff == 2'h0 || (pop && cnt_ff == 2'h1)))
         head_ff <= in_data_i;
      if (push && (cnt_ff == 2'h2 || (cnt_ff == 2'h1 && !pop)))
         tail_ff <= in_data_i;
      else if (push && pop && cnt_ff == 2'h2)
         tail_ff <= in_data_i;
   end

endmodule

// file: verification/tsm_line_src.sv
`timescale 1ns/1ps
module tsm_line_src
   import tsm_pkg::*;
(
   input  wire logic       clk_sys_i,  // Clock.
   input  wire logic       run_i,      // Send frames.
   input  wire logic       flip_i,     // Invert one F-bit.
   input  wire logic [3:0] flip_frm_i, // Frame of that F-bit.
   output logic            line_clk_o, // Bit clock.
   output logic            line_bit_o  // Line bit.
);
   logic [3:0] frm_ff = 4'h0;
   logic [7:0] pos_ff = 8'h00;
   logic [2:0] ph_ff  = 3'h0;
   logic       ck_ff  = 1'b0;
   logic       bit_ff = 1'b1;
   // Next bit is the pattern F-bit or a byte naming its channel, MSB first.
   wire logic       f_end   = pos_ff == FRAME_LAST;
   wire logic [7:0] nxt_pos = f_end ? 8'h00 : pos_ff + 8'h01;
   wire logic [3:0] nxt_frm = !f_end ? frm_ff :
      (frm_ff == SUB_LAST) ? 4'h0 : frm_ff + 4'h1;
   wire logic [7:0] ofs     = nxt_pos - ONE_BIT;
   wire logic [7:0] chan_v  = {3'h5, ofs[7:3]};
   wire logic       nxt_bit = (nxt_pos == 8'h00) ?
      SF_PAT[4'hB - nxt_frm] ^ (flip_i && flip_frm_i == nxt_frm) :
      chan_v[3'h7 - ofs[2:0]];
   assign line_clk_o = ck_ff;
   assign line_bit_o = bit_ff;
   // Six cycles a bit: the bit changes with the clock low, three high.
   always @(posedge clk_sys_i)
   begin
      if (run_i)
      begin
         ph_ff <= (ph_ff == 3'h5) ? 3'h0 : ph_ff + 3'h1;
         ck_ff <= ph_ff inside {3'h2, 3'h3, 3'h4};
         if (ph_ff == 3'h5)
         begin
            pos_ff <= nxt_pos;
            frm_ff <= nxt_frm;
            bit_ff <= nxt_bit;
         end
      end
   end
endmodule

// file: verification/t1_slc_sf_frame_sync_monitor_tb.sv
`timescale 1ns/1ps
module t1_slc_sf_frame_sync_monitor_tb;
   import tsm_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        reset_i   = 1'b1;
   logic        run = 1'b0, flip = 1'b0, trig = 1'b0, rdy = 1'b0;
   logic        stall = 1'b0, chk_w = 1'b0, drop_seen = 1'b0, auto = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic [3:0]  fsel = 4'h0, wf = 4'h0;
   logic [4:0]  clr = 5'h00, wc = 5'h00;
   logic        lck, lbit, oof, mfb, sev, fbe, cofa, oofc, irq, pme, wv, drp;
   logic [22:0] wd;
   int          failures = 0, checks_done = 0, cyc = 0, seed;
   logic        note_q[$];
   wire logic [20:0] w_exp = {3'h0, wf, wc,
      wf == ROB_SUB_A || wf == ROB_SUB_B, 3'h5, wc};
   tsm_line_src i_src (.clk_sys_i, .run_i(run), .flip_i(flip),
      .flip_frm_i(fsel), .line_clk_o(lck), .line_bit_o(lbit));
   tsm_frame_sync i_dut (.clk_sys_i, .reset_i, .rx_line_clk_i(lck),
      .rx_line_bit_i(lbit), .slc_format_i(1'b0),
      .loss_threshold_select_i(sel), .auto_reframe_enable_i(auto),
      .manual_reframe_trigger_i(trig), .ind_clear_i(clr),
      .ind_enable_i(5'h04), .out_of_frame_status_o(oof),
      .multiframe_boundary_ind_o(mfb), .severe_framing_error_ind_o(sev),
      .framing_bit_error_ind_o(fbe), .alignment_change_ind_o(cofa),
      .oof_change_ind_o(oofc), .irq_o(irq), .pm_fbit_err_o(pme),
      .pm_align_change_o(), .oh_valid_o(), .oh_bit_o(), .oh_frame_o(),
      .word_valid_o(wv), .word_ready_i(rdy), .word_data_o(wd),
      .word_drop_o(drp));
   // Compare, count and report.
   task automatic check(input string nm, input logic [22:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Print the verdict and stop.
   task automatic close_out();
      if (failures == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Wait until the source reaches a frame and bit position.
   task automatic at(input logic [3:0] fr, input logic [7:0] p);
      do @(posedge clk_sys_i); while (i_src.frm_ff != fr || i_src.pos_ff != p);
   endtask
   // Corrupt one F-bit; a report is expected only while aligned.
   task automatic hit(input logic [3:0] fr);
      if (oof === 1'b0)
         note_q.push_back(1'b1);
      fsel <= fr;
      flip <= 1'b1;
      at(fr, 8'h01);
      flip <= 1'b0;
      repeat (12) @(posedge clk_sys_i);
   endtask
   // Wait for the out-of-frame status to reach a level, then one more
   // edge so that the indications it sets have settled.
   task automatic sync(input logic want);
      do @(posedge clk_sys_i); while (oof !== want);
      @(posedge clk_sys_i);
   endtask
   // Clock, hang guard and a randomly stalling word taker.
   initial
   begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i)
   begin
      cyc <= cyc + 1;
      rdy <= !stall && ($urandom % 4 != 0);
      if (cyc == 100000)
      begin
         failures++;
         close_out();
      end
   end
   // Match each error pulse with a note and each taken word with its place.
   always @(posedge clk_sys_i)
   begin
      if (drp === 1'b1)
         drop_seen <= 1'b1;
      if (pme === 1'b1 && note_q.size() == 0)
         check("fbit_err", 1'b1, 1'b0);
      else if (pme === 1'b1)
         check("fbit_ind", fbe, note_q.pop_front());
      if (wv === 1'b1 && rdy === 1'b1 && chk_w)
      begin
         check("word", {wd[22:10], wd[7:0]}, w_exp);
         wc <= (wc == 5'h17) ? 5'h00 : wc + 5'h01;
         if (wc == 5'h17)
            wf <= (wf == SUB_LAST) ? 4'h0 : wf + 4'h1;
      end
   end
   // Main sequence: align, errors, overflow, loss, hold, manual hunt.
   initial
   begin
      seed = $urandom(29);
      repeat (20) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      check("oof_rst", oof, 1'b1);
      run <= 1'b1;
      sync(1'b0);
      wf <= SUB_LAST;
      chk_w <= 1'b1;
      check("oofc", oofc, 1'b1);
      check("cofa0", cofa, 1'b0);
      clr <= 5'h1F;
      @(posedge clk_sys_i);
      clr <= 5'h00;
      sel <= 2'h3;
      hit(4'h0);
      check("mfb", mfb, 1'b1);
      check("sev1", sev, 1'b0);
      check("irq1", irq, 1'b1);
      hit(4'h2);
      check("sev2", sev, 1'b1);
      clr <= 5'h04;
      @(posedge clk_sys_i);
      clr <= 5'h00;
      @(posedge clk_sys_i);
      check("fbe_clr", fbe, 1'b0);
      check("irq_mask", irq, 1'b0);
      chk_w <= 1'b0;
      stall <= 1'b1;
      repeat (200) @(posedge clk_sys_i);
      check("drop", drop_seen, 1'b1);
      stall <= 1'b0;
      do @(posedge clk_sys_i); while (wv !== 1'b0);
      sel <= 2'h0;
      for (int i = 4; i < 9; i++)
         hit(4'(i));
      check("loss", oof, 1'b1);
      repeat (3000) @(posedge clk_sys_i);
      check("hold", oof, 1'b1);
      trig <= 1'b1;
      sync(1'b0);
      check("cofa1", cofa, 1'b0);
      // Loss with auto reframe enabled must lead to a fresh alignment.
      auto <= 1'b1;
      for (int i = 4; i < 9; i++)
         hit(4'(i));
      check("loss_auto", oof, 1'b1);
      sync(1'b0);
      check("cofa2", cofa, 1'b0);
      check("pend", 23'(note_q.size()), 23'h0);
      close_out();
   end
endmodule
